// ---- logic/kspk_i2c_port.sv ----
// Two-wire serial register port of the key controller
// Behaviour
// - Write: address, then command byte selects register
// - Command then STOP only latches pointer
// - First data byte goes to pointed register
// - Further data bytes fill successive registers
// - Reads start at pointer, then advance
// - 0x00 stays, 0x06 wraps, ranges increment
// - Pointer moves only on burst data bytes
// - Config D7 and 0x40 D4 reset logic
// - Third key of rectangle is not reported
// - Any non-ghost key count accepted; a full queue drops the event
// - Static inputs; debounce runs only while a key is sampled or debounced down
// - Entry holds key number, D6 marks release
// - D7 set while more entries remain
// - Empty reads 0x3f, overflow reads 0x7f
// - Repeat entry 0x3e, D6 flags more
// - Acknowledge own 7-bit address after START
// - D7 low and GPI off means sleep
`timescale 1ns/10ps
module kspk_i2c_port #(
	parameter int DEB_CYC = kspk_pkg::DEB_CYC,
	parameter int REP_CYC = kspk_pkg::REP_CYC
) (
	input wire logic i_clk, // 20 MHz clock
	input wire logic i_nrst, // Async reset, low
	input wire logic i_ce, // Clock enable
	input wire logic i_scl, // Bus clock in
	input wire logic i_sda, // Bus data in
	output logic o_sda_out, // Bus data out level
	output logic o_sda_oe, // Bus data drive enable
	input wire logic [55:0] i_keys, // Key levels
	output logic o_sleep, // Chip in sleep
	output logic o_gpio_run // GPIO logic enabled
);
	kspk_pkg::kspk_state_e st_r;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [2:0] bit_cnt_r;
	logic [7:0] sh_r, tx_r, rx_byte, ptr_r;
	logic rw_r, cmd_wait_r, ack_on_r, mack_r, sda_oe_r;
	logic rx_done, cmd_stb, wr_stb, ld_stb, pop;
	logic [7:0] cfg_r, slp_r, gcfg_r, rd_data, entry;
	logic any_key, sleep;

	// Pointer step for the burst that just moved a byte
	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		if (p == kspk_pkg::REG_QUEUE || p == kspk_pkg::REG_SLEEP) begin
			ptr_next = kspk_pkg::REG_QUEUE;
		end else if ((p >= kspk_pkg::REG_CFG &&
				p <= kspk_pkg::REG_KEY_LAST) ||
				(p >= kspk_pkg::REG_GPIO_FIRST &&
				p <= kspk_pkg::REG_GPIO_LAST)) begin
			ptr_next = p + kspk_pkg::PTR_STEP;
		end else begin
			ptr_next = p;
		end
	endfunction

	// Read decode; unimplemented addresses return zero
	function automatic logic [7:0] reg_read(input logic [7:0] p,
			input logic [7:0] ent, input logic [7:0] cfg,
			input logic [7:0] slp, input logic [7:0] gcfg);
		case (p)
			kspk_pkg::REG_QUEUE: reg_read = ent;
			kspk_pkg::REG_CFG: reg_read = cfg;
			kspk_pkg::REG_SLEEP: reg_read = slp;
			kspk_pkg::REG_GCFG: reg_read = gcfg;
			default: reg_read = 8'h00;
		endcase
	endfunction

	// Pins are synchronous; one stage of history finds edges
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (i_ce) begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	assign scl_rise = i_scl & ~scl_q;
	assign scl_fall = ~i_scl & scl_q;
	assign start_det = i_scl & scl_q & sda_q & ~i_sda;
	assign stop_det = i_scl & scl_q & ~sda_q & i_sda;
	assign rx_byte = {sh_r[6:0], i_sda};

	// Byte strobes towards the register side
	assign rx_done = i_ce && st_r == kspk_pkg::ST_RX && scl_rise &&
		bit_cnt_r == 3'h7 && !start_det && !stop_det;
	assign cmd_stb = rx_done && cmd_wait_r;
	assign wr_stb = rx_done && !cmd_wait_r;
	assign ld_stb = i_ce && scl_fall && !start_det && !stop_det &&
		((st_r == kspk_pkg::ST_ACK && ack_on_r && rw_r) ||
		(st_r == kspk_pkg::ST_RACK && mack_r));
	assign pop = ld_stb && ptr_r == kspk_pkg::REG_QUEUE;
	assign rd_data = reg_read(ptr_r, entry, cfg_r, slp_r, gcfg_r);

	// Protocol engine: address match, ack slot, byte shifting
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= kspk_pkg::ST_IDLE;
			bit_cnt_r <= '0;
			sh_r <= '0;
			tx_r <= '0;
			rw_r <= 1'b0;
			cmd_wait_r <= 1'b0;
			ack_on_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (i_ce) begin
			if (start_det) begin
				// Pointer survives a repeated START
				st_r <= kspk_pkg::ST_ADDR;
				bit_cnt_r <= '0;
				sda_oe_r <= 1'b0;
				ack_on_r <= 1'b0;
			end else if (stop_det) begin
				st_r <= kspk_pkg::ST_IDLE;
				sda_oe_r <= 1'b0;
				cmd_wait_r <= 1'b0;
			end else begin
				case (st_r)
					kspk_pkg::ST_IDLE: begin
						sda_oe_r <= 1'b0;
					end
					kspk_pkg::ST_ADDR: begin
						if (scl_rise) begin
							sh_r <= rx_byte;
							bit_cnt_r <= bit_cnt_r + 3'h1;
							if (bit_cnt_r == 3'h7) begin
								if (rx_byte[7:1] == kspk_pkg::SLV_ADDR) begin
									st_r <= kspk_pkg::ST_ACK;
									rw_r <= rx_byte[0];
									cmd_wait_r <= ~rx_byte[0];
								end else begin
									st_r <= kspk_pkg::ST_IDLE;
								end
							end
						end
					end
					kspk_pkg::ST_RX: begin
						if (scl_rise) begin
							sh_r <= rx_byte;
							bit_cnt_r <= bit_cnt_r + 3'h1;
							if (bit_cnt_r == 3'h7) begin
								st_r <= kspk_pkg::ST_ACK;
								cmd_wait_r <= 1'b0;
							end
						end
					end
					kspk_pkg::ST_ACK: begin
						if (scl_fall && !ack_on_r) begin
							ack_on_r <= 1'b1;
							sda_oe_r <= 1'b1;
						end else if (scl_fall) begin
							ack_on_r <= 1'b0;
							bit_cnt_r <= '0;
							if (rw_r) begin
								st_r <= kspk_pkg::ST_TX;
								tx_r <= rd_data;
								sda_oe_r <= ~rd_data[7];
							end else begin
								st_r <= kspk_pkg::ST_RX;
								sda_oe_r <= 1'b0;
							end
						end
					end
					kspk_pkg::ST_TX: begin
						if (scl_fall) begin
							bit_cnt_r <= bit_cnt_r + 3'h1;
							if (bit_cnt_r == 3'h7) begin
								st_r <= kspk_pkg::ST_RACK;
								sda_oe_r <= 1'b0;
							end else begin
								tx_r <= {tx_r[6:0], 1'b0};
								sda_oe_r <= ~tx_r[6];
							end
						end
					end
					kspk_pkg::ST_RACK: begin
						if (scl_rise) begin
							mack_r <= ~i_sda;
						end else if (scl_fall && mack_r) begin
							st_r <= kspk_pkg::ST_TX;
							bit_cnt_r <= '0;
							tx_r <= rd_data;
							sda_oe_r <= ~rd_data[7];
						end else if (scl_fall) begin
							// Master ended the read with a NACK
							st_r <= kspk_pkg::ST_IDLE;
						end
					end
					default: begin
						st_r <= kspk_pkg::ST_IDLE;
						sda_oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_r;

	// Address pointer: latched by command, stepped per data byte
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ptr_r <= kspk_pkg::REG_QUEUE;
		end else if (i_ce) begin
			if (cmd_stb) begin
				ptr_r <= rx_byte;
			end else if (wr_stb || ld_stb) begin
				ptr_r <= ptr_next(ptr_r);
			end
		end
	end

	// Configuration: writes, plus keypress wake from sleep
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_r <= kspk_pkg::CFG_RST;
		end else if (i_ce) begin
			if (wr_stb && ptr_r == kspk_pkg::REG_CFG) begin
				cfg_r <= rx_byte & kspk_pkg::CFG_WMASK;
			end else if (sleep && cfg_r[kspk_pkg::CFG_WAKE_BIT] &&
					any_key) begin
				cfg_r[kspk_pkg::CFG_RUN_BIT] <= 1'b1;
			end
		end
	end

	// Sleep timeout and port global configuration storage
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			slp_r <= kspk_pkg::SLEEP_RST;
			gcfg_r <= kspk_pkg::GCFG_RST;
		end else if (i_ce && wr_stb) begin
			if (ptr_r == kspk_pkg::REG_SLEEP) begin
				slp_r <= rx_byte;
			end
			if (ptr_r == kspk_pkg::REG_GCFG) begin
				gcfg_r <= rx_byte;
			end
		end
	end

	// Sleep holds the key logic cleared, acting as its soft reset
	assign sleep = ~cfg_r[kspk_pkg::CFG_RUN_BIT] &
		~gcfg_r[kspk_pkg::GCFG_GPI_BIT];
	assign o_sleep = sleep;
	assign o_gpio_run = gcfg_r[kspk_pkg::GCFG_GPI_BIT];

	kspk_key_queue #(
		.DEB_CYC(DEB_CYC),
		.REP_CYC(REP_CYC)
	) u_queue (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_clr(sleep),
		.i_keys(i_keys),
		.i_rel_en(cfg_r[kspk_pkg::CFG_REL_BIT]),
		.i_pop(pop),
		.o_entry(entry),
		.o_any_key(any_key)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_cmd;
		cmd_stb;
	endsequence
	sequence s_latched;
		ptr_r == $past(rx_byte) ##0 $stable(gcfg_r) ##0 $stable(slp_r);
	endsequence
	property p_cmd;
		s_cmd |=> s_latched;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command not latched");
	property p_wr_cfg;
		(wr_stb && ptr_r == 8'h01)
			|=> cfg_r == ($past(rx_byte) & 8'hab) && ptr_r == 8'h02;
	endproperty
	a_wr_cfg: assert property (p_wr_cfg) else $error("cfg write");
	property p_wrap;
		((wr_stb || ld_stb) && ptr_r == 8'h06) |=> ptr_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");
	property p_stay;
		((wr_stb || ld_stb) && ptr_r == 8'h00) |=> ptr_r == 8'h00;
	endproperty
	a_stay: assert property (p_stay) else $error("queue ptr moved");
	property p_hold;
		(i_ce && !cmd_stb && !wr_stb && !ld_stb) |=> $stable(ptr_r);
	endproperty
	a_hold: assert property (p_hold) else $error("stray advance");
	sequence s_ack_slot;
		i_ce && scl_fall && !start_det && !stop_det &&
			st_r == kspk_pkg::ST_ACK && !ack_on_r;
	endsequence
	property p_ack;
		s_ack_slot |=> o_sda_oe && !o_sda_out;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_addr;
		(i_ce && st_r == kspk_pkg::ST_ADDR && scl_rise && !start_det &&
			!stop_det && bit_cnt_r == 3'h7 && rx_byte[7:1] != 7'h38)
			|=> st_r == kspk_pkg::ST_IDLE ##1 !o_sda_oe;
	endproperty
	a_addr: assert property (p_addr) else $error("foreign addr");
	property p_load;
		ld_stb |=> tx_r == $past(rd_data) && o_sda_oe == !tx_r[7];
	endproperty
	a_load: assert property (p_load) else $error("read data");
endmodule

// ---- inc/kspk_pkg.sv ----
// Constants and types shared by the key controller serial port design
package kspk_pkg;
	// Bus address (7-bit form of 0x70) and register map
	localparam logic [6:0] SLV_ADDR = 7'h38;
	localparam logic [7:0] REG_QUEUE = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_KEY_LAST = 8'h05;
	localparam logic [7:0] REG_SLEEP = 8'h06;
	localparam logic [7:0] REG_GPIO_FIRST = 8'h30;
	localparam logic [7:0] REG_GCFG = 8'h40;
	localparam logic [7:0] REG_GPIO_LAST = 8'h48;
	localparam logic [7:0] PTR_STEP = 8'h01;
	// Configuration fields and reset values
	localparam logic [7:0] CFG_RST = 8'h0b;
	localparam logic [7:0] CFG_WMASK = 8'hab;
	localparam logic [7:0] SLEEP_RST = 8'h00;
	localparam logic [7:0] GCFG_RST = 8'h00;
	localparam int CFG_RUN_BIT = 7;
	localparam int CFG_REL_BIT = 3;
	localparam int CFG_WAKE_BIT = 1;
	localparam int GCFG_GPI_BIT = 4;
	// Key queue entry encodings
	localparam logic [7:0] ENT_EMPTY = 8'h3f;
	localparam logic [7:0] ENT_OVF = 8'h7f;
	localparam logic [5:0] KEY_REPEAT = 6'h3e;
	localparam int ENT_KIND_BIT = 7;
	localparam int ENT_REL_BIT = 6;
	localparam int NKEYS = 56;
	localparam int NROWS = 8;
	localparam int QDEPTH = 16;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int DEB_TIME_US = 1000;
	localparam int DEB_CYC = CLK_HZ / 1_000_000 * DEB_TIME_US;
	localparam int REP_TIME_MS = 500;
	localparam int REP_CYC = CLK_HZ / 1000 * REP_TIME_MS;
	// Serial port states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_RX = 6'h04,
		ST_ACK = 6'h08,
		ST_TX = 6'h10,
		ST_RACK = 6'h20
	} kspk_state_e;
endpackage

// ---- logic/kspk_key_queue.sv ----
// Key debounce, ghost-key filter and 16-entry key event queue
`timescale 1ns/10ps
module kspk_key_queue #(
	parameter int DEB_CYC = kspk_pkg::DEB_CYC,
	parameter int REP_CYC = kspk_pkg::REP_CYC
) (
	input wire logic i_clk, // System clock
	input wire logic i_nrst, // Async reset, low
	input wire logic i_ce, // Clock enable
	input wire logic i_clr, // Sleep / soft reset
	input wire logic [55:0] i_keys, // Raw key levels
	input wire logic i_rel_en, // Report releases
	input wire logic i_pop, // Remove head entry
	output logic [7:0] o_entry, // Encoded head entry
	output logic o_any_key // Some key is down
);
	logic [55:0] samp_r, stable_r, acc_r, ghost, cand;
	logic [19:0] deb_cnt_r;
	logic [31:0] rep_cnt_r;
	logic [7:0] mem [kspk_pkg::QDEPTH];
	logic [3:0] wp_r, rp_r;
	logic [4:0] cnt_r;
	logic ovf_r, push;
	logic [7:0] push_ent;
	logic [7:0] row_a;
	logic [6:0] col_a;
	logic [7:0] row_two;
	logic [7:0] row_l;
	logic [6:0] col_two;
	logic [6:0] col_l;
	logic [5:0] idx;

	function automatic logic [5:0] first_set(input logic [55:0] v);
		first_set = 6'h00;
		for (int k = kspk_pkg::NKEYS - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = 6'(k);
			end
		end
	endfunction

	assign o_any_key = |i_keys;

	// Static debounce; counter idles while no key is sampled down and none is debounced down
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			samp_r <= '0;
			stable_r <= '0;
			deb_cnt_r <= '0;
		end else if (i_ce) begin
			if (i_clr) begin
				samp_r <= '0;
				stable_r <= '0;
				deb_cnt_r <= '0;
			end else if (i_keys != samp_r) begin
				samp_r <= i_keys;
				deb_cnt_r <= '0;
			end else if (deb_cnt_r == 20'(DEB_CYC - 1)) begin
				stable_r <= samp_r;
			end else if ((|samp_r) || (|stable_r)) begin
				deb_cnt_r <= deb_cnt_r + 20'h00001;
			end
		end
	end

	// Rectangle test: a new key that closes any L of accepted keys is a
	// ghost, whether it lands on the corner or on either end of the L
	always_comb begin
		row_a = '0;
		col_a = '0;
		row_two = '0;
		col_two = '0;
		row_l = '0;
		col_l = '0;
		// Rows and columns holding one, and two or more, accepted keys
		for (int k = 0; k < kspk_pkg::NKEYS; k++) begin
			if (acc_r[k]) begin
				row_two[k % kspk_pkg::NROWS] =
					row_two[k % kspk_pkg::NROWS] |
					row_a[k % kspk_pkg::NROWS];
				col_two[k / kspk_pkg::NROWS] =
					col_two[k / kspk_pkg::NROWS] |
					col_a[k / kspk_pkg::NROWS];
				row_a[k % kspk_pkg::NROWS] = 1'b1;
				col_a[k / kspk_pkg::NROWS] = 1'b1;
			end
		end
		// Accepted keys that form the bend of an L with a mate
		for (int k = 0; k < kspk_pkg::NKEYS; k++) begin
			if (acc_r[k]) begin
				col_l[k / kspk_pkg::NROWS] =
					col_l[k / kspk_pkg::NROWS] |
					row_two[k % kspk_pkg::NROWS];
				row_l[k % kspk_pkg::NROWS] =
					row_l[k % kspk_pkg::NROWS] |
					col_two[k / kspk_pkg::NROWS];
			end
		end
		for (int k = 0; k < kspk_pkg::NKEYS; k++) begin
			ghost[k] = (row_a[k % kspk_pkg::NROWS] &
				col_a[k / kspk_pkg::NROWS]) |
				col_l[k / kspk_pkg::NROWS] |
				row_l[k % kspk_pkg::NROWS];
		end
	end
	// Any number of keys pass unless they close a rectangle
	assign cand = (stable_r & ~acc_r & ~ghost) | (acc_r & ~stable_r);
	assign idx = first_set(cand);

	// One event per cycle; repeat entry while keys stay held
	always_comb begin
		push = 1'b0;
		push_ent = '0;
		if (|cand) begin
			push = stable_r[idx] | i_rel_en;
			push_ent = {1'b0, ~stable_r[idx], idx};
		end else if ((|acc_r) && rep_cnt_r == 32'(REP_CYC - 1)) begin
			push = 1'b1;
			push_ent = {1'b1, 1'b0, kspk_pkg::KEY_REPEAT};
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_r <= '0;
			rep_cnt_r <= '0;
		end else if (i_ce) begin
			if (i_clr) begin
				acc_r <= '0;
				rep_cnt_r <= '0;
			end else if (|cand) begin
				acc_r[idx] <= stable_r[idx];
				rep_cnt_r <= '0;
			end else if ((|acc_r) && rep_cnt_r != 32'(REP_CYC - 1)) begin
				rep_cnt_r <= rep_cnt_r + 32'h1;
			end else begin
				rep_cnt_r <= '0;
			end
		end
	end

	// Queue storage; a full queue drops the event and flags overflow
	always_ff @(posedge i_clk) begin
		if (i_ce && !i_clr && push && cnt_r != 5'(kspk_pkg::QDEPTH)) begin
			mem[wp_r] <= push_ent;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			ovf_r <= 1'b0;
		end else if (i_ce) begin
			if (i_clr) begin
				wp_r <= '0;
				rp_r <= '0;
				cnt_r <= '0;
				ovf_r <= 1'b0;
			end else begin
				logic do_push, do_pop;
				do_push = push && cnt_r != 5'(kspk_pkg::QDEPTH);
				do_pop = i_pop && !ovf_r && cnt_r != 5'h00;
				if (do_push) begin
					wp_r <= wp_r + 4'h1;
				end
				if (do_pop) begin
					rp_r <= rp_r + 4'h1;
				end
				cnt_r <= cnt_r + 5'(do_push) - 5'(do_pop);
				// Dropped event beats the read that clears the flag
				if (push && !do_push) begin
					ovf_r <= 1'b1;
				end else if (i_pop) begin
					ovf_r <= 1'b0;
				end
			end
		end
	end

	// Entry encoding seen by the register reader
	always_comb begin
		logic [7:0] e;
		logic more;
		e = mem[rp_r];
		more = cnt_r > 5'h01;
		if (ovf_r) begin
			o_entry = kspk_pkg::ENT_OVF;
		end else if (cnt_r == 5'h00) begin
			o_entry = kspk_pkg::ENT_EMPTY;
		end else if (e[kspk_pkg::ENT_KIND_BIT]) begin
			o_entry = {1'b0, more, kspk_pkg::KEY_REPEAT};
		end else begin
			o_entry = {more, e[kspk_pkg::ENT_REL_BIT], e[5:0]};
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_pop;
		(i_ce && i_pop && !i_clr && !ovf_r && cnt_r != 5'h00 && !push)
			|=> cnt_r == $past(cnt_r) - 5'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("pop lost");
	property p_empty;
		(cnt_r == 5'h00 && !ovf_r) |-> o_entry == 8'h3f;
	endproperty
	a_empty: assert property (p_empty) else $error("bad empty");
	property p_ghost;
		(push && (|cand)) |-> !(ghost[idx] && stable_r[idx] && !acc_r[idx]);
	endproperty
	a_ghost: assert property (p_ghost) else $error("ghost sent");
	property p_deb;
		(i_ce && !i_clr && i_keys == samp_r && !(|samp_r) && !(|stable_r))
			|=> $stable(deb_cnt_r);
	endproperty
	a_deb: assert property (p_deb) else $error("idle debounce");
endmodule

// ---- verification/kspk_bus_model.sv ----
// Two-wire bus master model facing the key controller port
`timescale 1ns/10ps
module kspk_bus_model (
	input wire logic i_clk, // System clock
	input wire logic i_sda, // Resolved data wire
	output logic o_scl, // Bus clock
	output logic o_sda // Data, 1 = released
);
	// Idle bus, both lines released high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Four clocks a phase clears the three-clock setup need
	task automatic gap(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// START or repeated START, ends with clock low
	task automatic start();
		o_sda = 1'b1;
		gap(4);
		o_scl = 1'b1;
		gap(4);
		o_sda = 1'b0;
		gap(4);
		o_scl = 1'b0;
		gap(2);
	endtask
	// STOP, data rises while clock high
	task automatic stop();
		o_sda = 1'b0;
		gap(4);
		o_scl = 1'b1;
		gap(4);
		o_sda = 1'b1;
		gap(4);
	endtask
	// One clock pulse; data held over the whole high phase
	task automatic xbit(input logic b, output logic r);
		o_sda = b;
		gap(4);
		o_scl = 1'b1;
		gap(4);
		r = i_sda;
		o_scl = 1'b0;
		gap(2);
	endtask
endmodule

// ---- verification/test_kspk_i2c_port.sv ----
// Self-checking bench for the key controller serial port
`timescale 1ns/10ps
module test_kspk_i2c_port;
	localparam int DEB = 8;
	localparam int REP = 200;
	logic clk, nrst, scl, m_sda, sda, sda_out, sda_oe, sleep, gpio_run;
	logic ce;
	logic [55:0] keys;
	logic [7:0] rb [0:19];
	logic [7:0] wd [0:3];
	logic [31:0] seed;
	logic [5:0] ka, kb, lo, hi;
	int errors, check_count;
	// Open-drain wire with pull-up
	assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
	kspk_i2c_port #(.DEB_CYC(DEB), .REP_CYC(REP)) uut (
		.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_keys(keys), .o_sleep(sleep), .o_gpio_run(gpio_run));
	kspk_bus_model bm (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Queue entry: more flag, release flag, key number
	function automatic logic [7:0] ent(input logic m, r, input logic [5:0] k);
		return {m, r, k};
	endfunction
	task automatic chk8(input string nm, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Send a byte and check the ninth-bit answer
	task automatic tx(input logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bm.xbit(d[i], r);
		bm.xbit(1'b1, r);
		chk1("ack", ack, ~r);
	endtask
	// Receive a byte; last one is refused to end the read
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bm.xbit(1'b1, r);
			d[i] = r;
		end
		bm.xbit(last, r);
	endtask
	task automatic wr(input logic [7:0] cmd, input int n);
		bm.start();
		tx(8'h70, 1'b1);
		tx(cmd, 1'b1);
		for (int i = 0; i < n; i++)
			tx(wd[i], 1'b1);
		bm.stop();
	endtask
	// Optional pointer set, then repeated START and burst read
	task automatic rd(input logic setp, input logic [7:0] cmd, input int n);
		if (setp) begin
			bm.start();
			tx(8'h70, 1'b1);
			tx(cmd, 1'b1);
		end
		bm.start();
		tx(8'h71, 1'b1);
		for (int i = 0; i < n; i++)
			rx(i == n - 1, rb[i]);
		bm.stop();
	endtask
	task automatic hold(input logic [55:0] k, input int n);
		keys = k;
		bm.gap(n);
	endtask
	// Bound is several times the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		finish_test();
	end
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		keys = '0;
		seed = 32'he603;
		errors = 0;
		check_count = 0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		chk1("sleep", 1'b1, sleep);
		chk1("gpio_run", 1'b0, gpio_run);
		// Reset values, pointer walk 0x01..0x06 then wrap
		rd(1'b1, 8'h01, 7);
		chk8("cfg", 8'h0b, rb[0]);
		chk8("timeout", 8'h00, rb[5]);
		chk8("queue", 8'h3f, rb[6]);
		rd(1'b1, 8'h40, 1);
		chk8("gcfg", 8'h00, rb[0]);
		// Foreign address is ignored
		bm.start();
		tx(8'h72, 1'b0);
		bm.stop();
		// Burst write across the 0x06 wrap
		seed = lfsr(seed);
		wd[0] = seed[7:0];
		wd[1] = seed[15:8];
		wd[2] = seed[23:16];
		wr(8'h05, 3);
		rd(1'b1, 8'h05, 3);
		chk8("reg05", 8'h00, rb[0]);
		chk8("timeout", wd[1], rb[1]);
		chk8("queue", 8'h3f, rb[2]);
		// Random values, then command alone and pointer reuse
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wd[0] = seed[31:24];
			wr(8'h06, 1);
			rd(1'b1, 8'h06, 1);
			chk8("timeout", wd[0], rb[0]);
		end
		wr(8'h06, 0);
		rd(1'b0, 8'h00, 2);
		chk8("timeout", wd[0], rb[0]);
		chk8("queue", 8'h3f, rb[1]);
		// Reserved configuration bits read zero
		wd[0] = 8'hff;
		wr(8'h01, 1);
		rd(1'b1, 8'h01, 1);
		chk8("cfg", 8'hab, rb[0]);
		wd[0] = 8'h88;
		wr(8'h01, 1);
		chk1("sleep", 1'b0, sleep);
		// Two random keys, released together
		seed = lfsr(seed);
		ka = 6'(seed[7:0] % 8'd56);
		kb = 6'((int'(ka) + 9) % 56);
		lo = (ka < kb) ? ka : kb;
		hi = (ka < kb) ? kb : ka;
		hold(56'h1 << ka, 30);
		hold(keys | (56'h1 << kb), 30);
		hold('0, 30);
		rd(1'b1, 8'h00, 5);
		chk8("press_a", ent(1'b1, 1'b0, ka), rb[0]);
		chk8("press_b", ent(1'b1, 1'b0, kb), rb[1]);
		chk8("rel_lo", ent(1'b1, 1'b1, lo), rb[2]);
		chk8("rel_hi", ent(1'b0, 1'b1, hi), rb[3]);
		chk8("queue", 8'h3f, rb[4]);
		// Held key makes one repeat entry
		hold(56'h1 << ka, DEB + REP + 60);
		hold('0, 30);
		rd(1'b1, 8'h00, 4);
		chk8("press", ent(1'b1, 1'b0, ka), rb[0]);
		chk8("repeat", 8'h7e, rb[1]);
		chk8("release", ent(1'b0, 1'b1, ka), rb[2]);
		// Third rectangle corner never reported
		hold(56'h101, 30);
		hold(56'h103, 30);
		hold('0, 30);
		rd(1'b1, 8'h00, 5);
		chk8("ghost_a", ent(1'b1, 1'b0, 6'h00), rb[0]);
		chk8("ghost_b", ent(1'b1, 1'b0, 6'h08), rb[1]);
		chk8("ghost_rel0", ent(1'b1, 1'b1, 6'h00), rb[2]);
		chk8("ghost_rel", ent(1'b0, 1'b1, 6'h08), rb[3]);
		chk8("ghost_end", 8'h3f, rb[4]);
		// Seven keys at once, twice over: queue overflows
		for (int i = 0; i < 2; i++) begin
			hold(56'h01010101010101, 30);
			hold('0, 30);
		end
		rd(1'b1, 8'h00, 18);
		chk8("overflow", 8'h7f, rb[0]);
		chk8("first", ent(1'b1, 1'b0, 6'h00), rb[1]);
		chk8("rel", ent(1'b1, 1'b1, 6'h00), rb[8]);
		chk8("last", ent(1'b0, 1'b0, 6'h08), rb[16]);
		chk8("queue", 8'h3f, rb[17]);
		// Enable low freezes the key logic: a tap seen only then is lost
		ce = 1'b0;
		hold(56'h10, 30);
		hold('0, 30);
		ce = 1'b1;
		rd(1'b1, 8'h00, 1);
		chk8("frozen", 8'h3f, rb[0]);
		// Sleep bit clears pending events
		hold(56'h20, 30);
		hold('0, 30);
		wd[0] = 8'h08;
		wr(8'h01, 1);
		chk1("sleep", 1'b1, sleep);
		rd(1'b1, 8'h00, 1);
		chk8("queue", 8'h3f, rb[0]);
		// Sleep with keypress wake enabled; a press ends the sleep
		wd[0] = 8'h0a;
		wr(8'h01, 1);
		chk1("sleep", 1'b1, sleep);
		hold(56'h4, 30);
		chk1("sleep", 1'b0, sleep);
		hold('0, 30);
		wd[0] = 8'h10;
		wr(8'h40, 1);
		chk1("gpio_run", 1'b1, gpio_run);
		chk1("sleep", 1'b0, sleep);
		finish_test();
	end
endmodule
